// *** rtl/ocf_output_config.sv ***
// The placing of the registers and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/1ns
// What this block does
// - Switches one to three each select latching for power outputs one to three.
// - Unlatched power output follows its trip request, held on for at least the minimum pulse length.
// - Latched power output stays on after the trip request falls away.
// - Latch released by front panel, digital input or serial bus request.
// - Switch four: signal output minimum pulse 80 ms at 0, 40 ms at 1.
// - Switch five: power output minimum pulse 80 ms at 0, 40 ms at 1.
// - Latching mode overrides the minimum pulse length for that power output.
// - Switch six: power output one starts breaker failure timer, then output two.
// - Switch seven at 0 routes restart disable to power output three.
// - Switch eight routes trip-circuit supervision warning onto signal output two.
// - All eight switches reset to 0, checksum 0.
// - Checksum is the sum of switch positions weighted 1, 2, 4 and upward.
module ocf_output_config
#(
    parameter int TICK_CYCLES = ocf_pkg::OCF_TICK_CYCLES
)
(
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [2:0] trip_request,
    input wire logic [1:0] signal_request,
    input wire logic restart_disable,
    input wire logic tcs_warning,
    input wire logic panel_unlatch,
    input wire logic unlatch_input_pin,
    output logic power_output_one,
    output logic power_output_two,
    output logic power_output_three,
    output logic signal_output_one,
    output logic signal_output_two,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////////////
    // Reset release
    logic [1:0] rst_sync_r;
    logic rst_q;

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rst_sync_r <= 2'b00;
        end
        else
        begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end

    assign rst_q = rst_sync_r[1];

    ////////////////////////////////////////////////////////////////////////////////
    // Millisecond tick
    logic [16:0] tick_cnt_r;
    logic [16:0] tick_cnt_nxt;
    logic tick_r;
    logic tick_nxt;

    always_comb
    begin
        tick_nxt = (tick_cnt_r == 17'(TICK_CYCLES - 1));
        tick_cnt_nxt = tick_nxt ? 17'h00000 : tick_cnt_r + 17'h00001;
    end

    always_ff @(posedge core_clk or negedge rst_q)
    begin
        if (!rst_q)
        begin
            tick_cnt_r <= 17'h00000;
            tick_r <= 1'b0;
        end
        else
        begin
            tick_cnt_r <= tick_cnt_nxt;
            tick_r <= tick_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Digital unlatch input synchroniser
    logic [2:0] din_sync_r;
    logic din_level_r;
    logic din_level_nxt;
    logic din_prev_r;

    always_comb
    begin
        din_level_nxt = (din_sync_r[1] == din_sync_r[2]) ? din_sync_r[2] : din_level_r;
    end

    always_ff @(posedge core_clk or negedge rst_q)
    begin
        if (!rst_q)
        begin
            din_sync_r <= 3'h0;
            din_level_r <= 1'b0;
            din_prev_r <= 1'b0;
        end
        else
        begin
            din_sync_r <= {din_sync_r[1:0], unlatch_input_pin};
            din_level_r <= din_level_nxt;
            din_prev_r <= din_level_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register bus
    logic wait_r;
    logic wait_nxt;
    logic [31:0] readdata_r;
    logic [31:0] readdata_nxt;
    logic [7:0] switches_r;
    logic [7:0] switches_nxt;
    logic [4:0] irq_mask_r;
    logic [4:0] irq_mask_nxt;
    logic [15:0] bf_time_r;
    logic [15:0] bf_time_nxt;
    logic bus_unlatch_r;
    logic bus_unlatch_nxt;
    logic [4:0] irq_status_r;
    logic [8:0] out_state;
    logic wr_go;
    logic rd_go;

    function automatic logic [31:0] ocf_checksum(input logic [7:0] sw);
        logic [31:0] sum;
        sum = 32'h00000000;
        for (int i = 0; i < 8; i++)
        begin
            sum = sum + (sw[i] ? (32'h00000001 << i) : 32'h00000000);
        end
        return sum;
    endfunction : ocf_checksum

    function automatic logic [31:0] ocf_read_mux(
        input logic [7:0] addr,
        input logic [7:0] sw,
        input logic [4:0] status,
        input logic [4:0] mask,
        input logic [8:0] state,
        input logic [15:0] bf_time
    );
        logic [31:0] data;
        data = 32'h00000000;
        unique case (addr)
            ocf_pkg::OCF_ADDR_SWITCHES: data = {24'h000000, sw};
            ocf_pkg::OCF_ADDR_CHECKSUM: data = ocf_checksum(sw);
            ocf_pkg::OCF_ADDR_IRQ_STATUS: data = {27'h0000000, status};
            ocf_pkg::OCF_ADDR_IRQ_MASK: data = {27'h0000000, mask};
            ocf_pkg::OCF_ADDR_OUT_STATE: data = {23'h000000, state};
            ocf_pkg::OCF_ADDR_BF_TIME: data = {16'h0000, bf_time};
            default: data = 32'h00000000;
        endcase
        return data;
    endfunction : ocf_read_mux

    assign wr_go = avs_write && !wait_r;
    assign rd_go = avs_read && !wait_r;

    always_comb
    begin
        wait_nxt = 1'b1;
        if ((avs_read || avs_write) && wait_r)
        begin
            wait_nxt = 1'b0;
        end
        readdata_nxt = readdata_r;
        if (avs_read && wait_r)
        begin
            readdata_nxt = ocf_read_mux(avs_address, switches_r, irq_status_r, irq_mask_r,
                                        out_state, bf_time_r);
        end
        switches_nxt = switches_r;
        irq_mask_nxt = irq_mask_r;
        bf_time_nxt = bf_time_r;
        bus_unlatch_nxt = 1'b0;
        if (wr_go)
        begin
            unique case (avs_address)
                ocf_pkg::OCF_ADDR_SWITCHES:
                begin
                    if (avs_byteenable[0])
                    begin
                        switches_nxt = avs_writedata[7:0];
                    end
                end
                ocf_pkg::OCF_ADDR_IRQ_MASK:
                begin
                    if (avs_byteenable[0])
                    begin
                        irq_mask_nxt = avs_writedata[4:0];
                    end
                end
                ocf_pkg::OCF_ADDR_BF_TIME:
                begin
                    if (avs_byteenable[0])
                    begin
                        bf_time_nxt[7:0] = avs_writedata[7:0];
                    end
                    if (avs_byteenable[1])
                    begin
                        bf_time_nxt[15:8] = avs_writedata[15:8];
                    end
                end
                ocf_pkg::OCF_ADDR_UNLATCH:
                begin
                    bus_unlatch_nxt = avs_byteenable[0]
                                      && avs_writedata[ocf_pkg::OCF_UNLATCH_BIT];
                end
                default:
                begin
                    bus_unlatch_nxt = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_q)
    begin
        if (!rst_q)
        begin
            wait_r <= 1'b1;
            readdata_r <= 32'h00000000;
            switches_r <= ocf_pkg::OCF_SWITCHES_RESET;
            irq_mask_r <= ocf_pkg::OCF_IRQ_MASK_RESET;
            bf_time_r <= ocf_pkg::OCF_BF_TIME_RESET;
            bus_unlatch_r <= 1'b0;
        end
        else
        begin
            wait_r <= wait_nxt;
            readdata_r <= readdata_nxt;
            switches_r <= switches_nxt;
            irq_mask_r <= irq_mask_nxt;
            bf_time_r <= bf_time_nxt;
            bus_unlatch_r <= bus_unlatch_nxt;
        end
    end

    assign avs_waitrequest = wait_r;
    assign avs_readdata = readdata_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Latches, breaker failure timer and output routing
    logic [2:0] latched_r;
    logic [2:0] latched_nxt;
    logic [15:0] bf_cnt_r;
    logic [15:0] bf_cnt_nxt;
    logic bf_trip_r;
    logic bf_trip_nxt;
    logic unlatch_any;
    logic [2:0] po_req;
    logic [4:0] drive;
    logic [4:0] short_sel;
    logic [4:0] stretched;
    logic [4:0] out_r;
    logic [4:0] out_nxt;
    logic tcs_prev_r;
    logic [4:0] events;

    always_comb
    begin
        unlatch_any = panel_unlatch || (din_level_r && !din_prev_r) || bus_unlatch_r;
        po_req[0] = trip_request[0];
        po_req[1] = trip_request[1] || bf_trip_r;
        po_req[2] = trip_request[2]
                    || (restart_disable && !switches_r[ocf_pkg::OCF_SW_RESTART_BLOCK]);
        for (int i = 0; i < 3; i++)
        begin
            if (switches_r[ocf_pkg::OCF_SW_LATCH_PO1 + i] && po_req[i])
            begin
                latched_nxt[i] = 1'b1;
            end
            else if (unlatch_any || !switches_r[ocf_pkg::OCF_SW_LATCH_PO1 + i])
            begin
                latched_nxt[i] = 1'b0;
            end
            else
            begin
                latched_nxt[i] = latched_r[i];
            end
        end
        bf_cnt_nxt = 16'h0000;
        bf_trip_nxt = 1'b0;
        if (switches_r[ocf_pkg::OCF_SW_BF_EN] && out_r[0] && trip_request[0])
        begin
            bf_cnt_nxt = (tick_r && bf_cnt_r != 16'hFFFF) ? bf_cnt_r + 16'h0001 : bf_cnt_r;
            bf_trip_nxt = (bf_cnt_r >= bf_time_r);
        end
        drive = {signal_request[1]
                 || (tcs_warning && switches_r[ocf_pkg::OCF_SW_TCS_TO_SO2]),
                 signal_request[0], po_req};
        short_sel = {{2{switches_r[ocf_pkg::OCF_SW_SHORT_SO]}},
                     {3{switches_r[ocf_pkg::OCF_SW_SHORT_PO]}}};
        out_nxt = stretched;
        for (int i = 0; i < 3; i++)
        begin
            if (switches_r[ocf_pkg::OCF_SW_LATCH_PO1 + i])
            begin
                out_nxt[i] = po_req[i] || latched_r[i];
            end
            else
            begin
                out_nxt[i] = stretched[i];
            end
        end
        events = {tcs_warning && !tcs_prev_r, bf_trip_nxt && !bf_trip_r,
                  out_nxt[2:0] & ~out_r[2:0]};
        out_state = {bf_trip_r, latched_r, out_r};
    end

    generate
        for (genvar g = 0; g < 5; g++)
        begin : g_pulse
            ocf_min_pulse u_pulse
            (
                .core_clk(core_clk),
                .rst_n(rst_q),
                .tick(tick_r),
                .drive(drive[g]),
                .short_sel(short_sel[g]),
                .stretched(stretched[g])
            );
        end
    endgenerate

    always_ff @(posedge core_clk or negedge rst_q)
    begin
        if (!rst_q)
        begin
            latched_r <= 3'h0;
            bf_cnt_r <= 16'h0000;
            bf_trip_r <= 1'b0;
            out_r <= 5'h00;
            tcs_prev_r <= 1'b0;
        end
        else
        begin
            latched_r <= latched_nxt;
            bf_cnt_r <= bf_cnt_nxt;
            bf_trip_r <= bf_trip_nxt;
            out_r <= out_nxt;
            tcs_prev_r <= tcs_warning;
        end
    end

    assign power_output_one = out_r[0];
    assign power_output_two = out_r[1];
    assign power_output_three = out_r[2];
    assign signal_output_one = out_r[3];
    assign signal_output_two = out_r[4];

    ////////////////////////////////////////////////////////////////////////////////
    // Interrupt status, cleared by reading it; a new event wins over the clear
    logic [4:0] irq_status_nxt;
    logic irq_r;
    logic irq_nxt;

    always_comb
    begin
        irq_status_nxt = irq_status_r;
        if (rd_go && avs_address == ocf_pkg::OCF_ADDR_IRQ_STATUS)
        begin
            irq_status_nxt = irq_status_r & ~readdata_r[ocf_pkg::OCF_EV_W-1:0];
        end
        irq_status_nxt = irq_status_nxt | events;
        irq_nxt = |(irq_status_r & irq_mask_r);
    end

    always_ff @(posedge core_clk or negedge rst_q)
    begin
        if (!rst_q)
        begin
            irq_status_r <= 5'h00;
            irq_r <= 1'b0;
        end
        else
        begin
            irq_status_r <= irq_status_nxt;
            irq_r <= irq_nxt;
        end
    end

    assign irq = irq_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_q);

    chk_latch_select: assert property (
        (switches_r[1] && po_req[1]) |=> latched_r[1])
        else $error("latch not taken for power output two");

    chk_latch_hold: assert property (
        (latched_r[0] && switches_r[0] && !unlatch_any) |=> (latched_r[0] && out_r[0]))
        else $error("latched power output one dropped");

    chk_unlatch_release: assert property (
        (latched_r[2] && unlatch_any && !po_req[2]) |=> !latched_r[2])
        else $error("unlatch request ignored");

    chk_bf_escalate: assert property (
        bf_trip_r |-> ($past(switches_r[ocf_pkg::OCF_SW_BF_EN]) && $past(bf_cnt_r) >= $past(bf_time_r))
        ##1 out_r[1])
        else $error("breaker failure escalation wrong");

    chk_restart_route: assert property (
        (restart_disable && !switches_r[ocf_pkg::OCF_SW_RESTART_BLOCK]) |=> out_r[2])
        else $error("restart disable not routed");

    chk_tcs_route: assert property (
        (tcs_warning && switches_r[ocf_pkg::OCF_SW_TCS_TO_SO2]) |=> out_r[4])
        else $error("supervision warning not routed");

    chk_switch_reset: assert property (
        $rose(rst_q) |-> (switches_r == 8'h00))
        else $error("switches not cleared by reset");

    chk_checksum_read: assert property (
        (avs_read && !wait_r && avs_address == ocf_pkg::OCF_ADDR_CHECKSUM)
        |-> (readdata_r == {24'h000000, switches_r}))
        else $error("checksum read mismatch");

    chk_bus_wait: assert property (
        ((avs_read || avs_write) && wait_r) |=> !wait_r ##1 wait_r)
        else $error("waitrequest sequence wrong");

    cov_bf_trip: cover property ($rose(bf_trip_r));
    cov_unlatch: cover property (latched_r[0] ##1 !latched_r[0]);
    cov_tcs_route: cover property (tcs_warning && switches_r[7] ##1 out_r[4]);
    cov_irq: cover property ($rose(irq_r));

endmodule : ocf_output_config

// *** rtl/ocf_pkg.sv ***
package ocf_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Register byte addresses
    localparam logic [7:0] OCF_ADDR_SWITCHES = 8'h00;
    localparam logic [7:0] OCF_ADDR_CHECKSUM = 8'h04;
    localparam logic [7:0] OCF_ADDR_IRQ_STATUS = 8'h08;
    localparam logic [7:0] OCF_ADDR_IRQ_MASK = 8'h0C;
    localparam logic [7:0] OCF_ADDR_UNLATCH = 8'h10;
    localparam logic [7:0] OCF_ADDR_OUT_STATE = 8'h14;
    localparam logic [7:0] OCF_ADDR_BF_TIME = 8'h18;

    ////////////////////////////////////////////////////////////////////////////////
    // Switch positions in output_function_switches
    localparam int OCF_SW_LATCH_PO1 = 0;
    localparam int OCF_SW_SHORT_SO = 3;
    localparam int OCF_SW_SHORT_PO = 4;
    localparam int OCF_SW_BF_EN = 5;
    localparam int OCF_SW_RESTART_BLOCK = 6;
    localparam int OCF_SW_TCS_TO_SO2 = 7;

    // Interrupt status and mask bits
    localparam int OCF_EV_PO1 = 0;
    localparam int OCF_EV_BF = 3;
    localparam int OCF_EV_TCS = 4;
    localparam int OCF_EV_W = 5;

    // Output state fields
    localparam int OCF_OS_LATCHED_LSB = 5;
    localparam int OCF_OS_BF = 8;

    // Unlatch command bit
    localparam int OCF_UNLATCH_BIT = 0;

    ////////////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [7:0] OCF_SWITCHES_RESET = 8'h00;
    localparam logic [4:0] OCF_IRQ_MASK_RESET = 5'h00;
    localparam logic [15:0] OCF_BF_TIME_RESET = 16'h0064;

    ////////////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int OCF_CLK_PERIOD_NS = 10;
    localparam int OCF_TICK_NS = 1000000;
    localparam int OCF_TICK_CYCLES = OCF_TICK_NS / OCF_CLK_PERIOD_NS;
    localparam int OCF_PULSE_LONG_MS = 80;
    localparam int OCF_PULSE_SHORT_MS = 40;
    localparam int OCF_PULSE_W = 7;

endpackage : ocf_pkg

// *** rtl/ocf_min_pulse.sv ***
`timescale 1ns/1ns
module ocf_min_pulse
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic tick,
    input wire logic drive,
    input wire logic short_sel,
    output logic stretched
);

    logic [ocf_pkg::OCF_PULSE_W-1:0] hold_cnt_r;
    logic [ocf_pkg::OCF_PULSE_W-1:0] hold_cnt_nxt;
    logic drive_r;
    logic [ocf_pkg::OCF_PULSE_W-1:0] load_val;

    ////////////////////////////////////////////////////////////////////////////////
    // Hold counter, one extra count so the least length rounds up
    always_comb
    begin
        load_val = short_sel ? ocf_pkg::OCF_PULSE_W'(ocf_pkg::OCF_PULSE_SHORT_MS + 1)
                             : ocf_pkg::OCF_PULSE_W'(ocf_pkg::OCF_PULSE_LONG_MS + 1);
        hold_cnt_nxt = hold_cnt_r;
        if (drive && !drive_r)
        begin
            hold_cnt_nxt = load_val;
        end
        else if (tick && hold_cnt_r != '0)
        begin
            hold_cnt_nxt = hold_cnt_r - 1'b1;
        end
        stretched = drive || (hold_cnt_r != '0);
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            hold_cnt_r <= '0;
            drive_r <= 1'b0;
        end
        else
        begin
            hold_cnt_r <= hold_cnt_nxt;
            drive_r <= drive;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    chk_pulse_load: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(drive) |=> (hold_cnt_r == (short_sel ? 7'h29 : 7'h51)))
        else $error("minimum pulse counter not loaded");

    chk_pulse_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
        (hold_cnt_r > 7'h01) |=> stretched)
        else $error("output released before minimum pulse length");

endmodule : ocf_min_pulse

// *** sim/ocf_relay_model.sv ***
`timescale 1ns/1ns
////////////////////////////////////////
// Protection elements and contact timers: holds requests, times contacts
module ocf_relay_model
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [4:0] fire,
    input wire logic [15:0] hold_len,
    input wire logic [4:0] contact,
    output logic [2:0] trip_request,
    output logic [1:0] signal_request,
    output logic [4:0][15:0] width_last
);
    logic [4:0][15:0] left_r, left_nxt, cnt_r, cnt_nxt, width_nxt;

    always_comb
    begin
        for (int i = 0; i < 5; i++)
        begin
            left_nxt[i] = (left_r[i] != 16'h0000) ? left_r[i] - 16'h0001 : 16'h0000;
            if (fire[i])
                left_nxt[i] = hold_len;
            cnt_nxt[i] = contact[i] ? cnt_r[i] + 16'h0001 : 16'h0000;
            width_nxt[i] = width_last[i];
            if (!contact[i] && cnt_r[i] != 16'h0000)
                width_nxt[i] = cnt_r[i];
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            left_r <= '0;
            cnt_r <= '0;
            width_last <= '0;
        end
        else
        begin
            left_r <= left_nxt;
            cnt_r <= cnt_nxt;
            width_last <= width_nxt;
        end
    end

    // Request stays high while the hold count left_r is above zero
    always_comb
    begin
        for (int i = 0; i < 3; i++)
            trip_request[i] = (left_r[i] != 16'h0000);
        for (int i = 0; i < 2; i++)
            signal_request[i] = (left_r[i + 3] != 16'h0000);
    end
endmodule : ocf_relay_model

// *** sim/ocf_output_config_tb.sv ***
`timescale 1ns/1ns
////////////////////////////////////////
module ocf_output_config_tb;
    localparam int T = 10;
    logic core_clk, arst_n, avs_read, avs_write, avs_waitrequest, irq;
    logic [7:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd, v;
    logic restart_disable, tcs_warning, panel_unlatch, unlatch_input_pin;
    logic [2:0] trip_request;
    logic [1:0] signal_request;
    logic [4:0] fire;
    logic [15:0] hold_len;
    logic [4:0][15:0] width_last;
    wire logic [4:0] contact;
    int failures, checks_done, n, p;

    ocf_output_config #(.TICK_CYCLES(T)) ocf_output_config_i (
        .core_clk(core_clk), .arst_n(arst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .trip_request(trip_request),
        .signal_request(signal_request), .restart_disable(restart_disable),
        .tcs_warning(tcs_warning), .panel_unlatch(panel_unlatch),
        .unlatch_input_pin(unlatch_input_pin), .power_output_one(contact[0]),
        .power_output_two(contact[1]), .power_output_three(contact[2]),
        .signal_output_one(contact[3]), .signal_output_two(contact[4]), .irq(irq));

    ocf_relay_model ocf_relay_model_i (
        .core_clk(core_clk), .rst_n(arst_n), .fire(fire), .hold_len(hold_len),
        .contact(contact), .trip_request(trip_request),
        .signal_request(signal_request), .width_last(width_last));

    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic print_verdict;
        if (failures == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : print_verdict

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            failures++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic cyc(input int k);
        repeat (k) @(posedge core_clk);
    endtask : cyc

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int w;
        w = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        @(negedge core_clk);
        while (avs_waitrequest !== 1'b0)
        begin
            w++;
            if (w > 20)
            begin
                failures++;
                print_verdict();
            end
            @(negedge core_clk);
        end
        rd = avs_readdata;
        @(posedge core_clk);
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge core_clk);
    endtask : bus

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        check(rd, e);
    endtask : rdchk

    task automatic shot(input logic [4:0] m, input logic [15:0] len);
        hold_len <= len;
        fire <= m;
        cyc(1);
        fire <= 5'h00;
    endtask : shot

    task automatic wait_for(input int i, input logic lv, input int lim);
        n = 0;
        while (contact[i] !== lv)
        begin
            n++;
            if (n > lim)
            begin
                failures++;
                print_verdict();
            end
            @(posedge core_clk);
        end
    endtask : wait_for

    function automatic logic [31:0] csum(input logic [7:0] s);
        csum = 32'h0;
        for (int i = 0; i < 8; i++)
            csum = csum + (s[i] ? (32'h1 << i) : 32'h0);
    endfunction : csum

    initial
    begin
        void'($urandom(32'hBDB4E24B));
        failures = 0;
        checks_done = 0;
        arst_n = 1'b0;
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        restart_disable = 1'b0;
        tcs_warning = 1'b0;
        panel_unlatch = 1'b0;
        unlatch_input_pin = 1'b0;
        fire = 5'h00;
        hold_len = 16'h0000;
        cyc(6);
        arst_n <= 1'b1;
        cyc(4);
        rdchk(ocf_pkg::OCF_ADDR_SWITCHES, 32'h0);
        rdchk(ocf_pkg::OCF_ADDR_CHECKSUM, 32'h0);
        rdchk(8'h40, 32'h0);
        for (int k = 0; k < 4; k++)
        begin
            v = $urandom;
            bus(1'b1, ocf_pkg::OCF_ADDR_SWITCHES, v);
            bus(1'b1, ocf_pkg::OCF_ADDR_CHECKSUM, 32'hFF);
            rdchk(ocf_pkg::OCF_ADDR_CHECKSUM, csum(v[7:0]));
        end
        // Minimum pulse lengths with random switch four and five
        for (int k = 0; k < 20; k++)
        begin
            v = $urandom;
            bus(1'b1, ocf_pkg::OCF_ADDR_SWITCHES, {27'h0, v[1:0], 3'h0});
            shot(5'h01 << (k % 5), 16'(1 + v[6:2]));
            wait_for(k % 5, 1'b1, 5);
            wait_for(k % 5, 1'b0, 90 * T);
            cyc(1);
            p = ((k % 5) < 3 ? v[1] : v[0]) ? 40 * T : 80 * T;
            check(width_last[k % 5] >= p && width_last[k % 5] <= p + 2 * T, 1);
        end
        shot(5'h02, 16'd1200);
        wait_for(1, 1'b1, 5);
        wait_for(1, 1'b0, 1300);
        cyc(1);
        check(width_last[1] >= 1200 && width_last[1] <= 1203, 1);
        // Latch one output at a time, release by each source in turn
        for (int k = 0; k < 3; k++)
        begin
            bus(1'b1, ocf_pkg::OCF_ADDR_SWITCHES, 32'h10 | (32'h1 << k));
            shot(5'h07, 16'd5);
            cyc(1000);
            check(contact[2:0], 32'h1 << k);
            if (k == 0)
                panel_unlatch <= 1'b1;
            else if (k == 1)
                unlatch_input_pin <= 1'b1;
            else
                bus(1'b1, ocf_pkg::OCF_ADDR_UNLATCH, 32'h1);
            cyc(6);
            panel_unlatch <= 1'b0;
            unlatch_input_pin <= 1'b0;
            cyc(4);
            check(contact[k], 0);
        end
        // Breaker failure escalation with interrupt
        bus(1'b1, ocf_pkg::OCF_ADDR_BF_TIME, 32'd5);
        bus(1'b1, ocf_pkg::OCF_ADDR_SWITCHES, 32'h20);
        bus(1'b1, ocf_pkg::OCF_ADDR_IRQ_MASK, 32'h8);
        bus(1'b0, ocf_pkg::OCF_ADDR_IRQ_STATUS, 32'h0);
        shot(5'h01, 16'd2000);
        wait_for(0, 1'b1, 5);
        wait_for(1, 1'b1, 10 * T);
        check(n >= 4 * T && n <= 6 * T + 4, 1);
        cyc(2);
        check(irq, 1);
        rdchk(ocf_pkg::OCF_ADDR_IRQ_STATUS, 32'h0B);
        cyc(2);
        check(irq, 0);
        wait_for(0, 1'b0, 2100);
        wait_for(1, 1'b0, 1000);
        bus(1'b1, ocf_pkg::OCF_ADDR_SWITCHES, 32'h0);
        bus(1'b1, ocf_pkg::OCF_ADDR_IRQ_MASK, 32'h0);
        shot(5'h01, 16'd200);
        cyc(150);
        check(contact[1], 0);
        check(irq, 0);
        wait_for(0, 1'b0, 1000);
        // Restart disable routing
        bus(1'b1, ocf_pkg::OCF_ADDR_SWITCHES, 32'h40);
        restart_disable <= 1'b1;
        cyc(5);
        check(contact[2], 0);
        bus(1'b1, ocf_pkg::OCF_ADDR_SWITCHES, 32'h0);
        cyc(3);
        check(contact[2], 1);
        restart_disable <= 1'b0;
        wait_for(2, 1'b0, 90 * T);
        // Supervision warning routing, signal output two request kept low
        tcs_warning <= 1'b1;
        cyc(5);
        check(contact[4], 0);
        bus(1'b1, ocf_pkg::OCF_ADDR_SWITCHES, 32'h80);
        cyc(3);
        check(contact[4], 1);
        tcs_warning <= 1'b0;
        wait_for(4, 1'b0, 90 * T);
        print_verdict();
    end
endmodule : ocf_output_config_tb
